/* startup_fault_response_and_turnoff_delay.sv */
// Start-up timeout response, restart sequencing and turn-off delay.
// Assumes commands arrive already decoded from the management bus,
// and that the timeout limit and rise time are given in whole ms.
`timescale 1ns/1ps
module startup_fault_response_and_turnoff_delay #(
	parameter int CYC_PER_MS = fault_delay_pkg::CYCLES_PER_MS
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Command port
	input wire logic [7:0] cmd_code,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic [15:0] cmd_wdata,
	output logic [15:0] cmd_rdata,
	output logic cmd_ack,
	output logic cmd_nack,
	// Nonvolatile store and restore
	input wire logic store_all,
	input wire logic nv_load,
	input wire logic nv_ignore_select,
	input wire logic nv_retry_bit,
	input wire logic [fault_delay_pkg::MANT_W-1:0] nv_toff_mant,
	output logic nv_store,
	output logic [7:0] nv_action_byte,
	output logic [fault_delay_pkg::MANT_W-1:0] nv_toff_data,
	// Power stage and pins
	input wire logic loop_slave_pin,
	input wire logic out_below_uvf_pin,
	input wire logic on_cmd,
	input wire logic other_fault_shutdown,
	input wire logic [11:0] startup_timeout_limit,
	input wire logic [7:0] soft_start_rise_time,
	output logic ramp_up,
	output logic regulating,
	output logic ramp_down,
	// Status
	input wire logic fault_clear,
	input wire logic startup_timeout_mask,
	output logic startup_timeout_flag,
	output logic other_fault,
	output logic output_fault_word_bit,
	output logic communication_fault_summary,
	output logic invalid_data_flag,
	output logic invalid_command_fault,
	output logic alert_b
);
	import fault_delay_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] s1_q, s2_q, s3_q, pin_q, pin_d;
	logic loop_slave, below_uvf;

	// A level change counts once the second and third stages agree
	always_comb begin
		pin_d = pin_q;
		for (int i = 0; i < 2; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				pin_d[i] = s3_q[i];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			pin_q <= '0;
		end else begin
			s1_q <= {out_below_uvf_pin, loop_slave_pin};
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= pin_d;
		end
	end
	assign loop_slave = pin_q[0];
	assign below_uvf = pin_q[1];

	// ----------------------------------------------------------------
	// Delay bucket lookup
	// ----------------------------------------------------------------
	function automatic logic [MANT_W-1:0] bucket_ms(input logic [MANT_W-1:0] m);
		logic [MANT_W-1:0] r;
		r = MS_100;
		if (m <= EDGE_DIRECT) r = m;
		else if (m <= EDGE_7) r = MS_7;
		else if (m <= EDGE_10) r = MS_10;
		else if (m <= EDGE_14) r = MS_14;
		else if (m <= EDGE_19) r = MS_19;
		else if (m <= EDGE_27) r = MS_27;
		else if (m <= EDGE_37) r = MS_37;
		else if (m <= EDGE_52) r = MS_52;
		else if (m <= EDGE_72) r = MS_72;
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Command registers and status flags
	// ----------------------------------------------------------------
	logic ign_q, ign_d, retry_q, retry_d;
	logic [MANT_W-1:0] mant_q, mant_d;
	logic [15:0] rdata_d;
	logic ack_d, nack_d, store_d;
	logic tmo_q, tmo_d, ivd_q, ivd_d, ivc_q, ivc_d;
	logic tmo_event, req, hit, bad_retry;
	logic [7:0] action_byte;
	logic [2:0] wr_retry;

	// Delay bits mirror bit 5; bit 6 reads zero
	assign action_byte = {ign_q, 1'b0, {3{retry_q}}, {3{retry_q}}};
	assign wr_retry = cmd_wdata[RETRY_HI:RETRY_LO];
	assign bad_retry = (wr_retry != RETRY_OFF) && (wr_retry != RETRY_ON);
	assign req = cmd_wr || cmd_rd;
	assign hit = (cmd_code == CMD_STARTUP_ACTION) || (cmd_code == CMD_TURN_OFF_DELAY);

	// Decode; a flag set in the cycle of a clear still sets
	always_comb begin
		ign_d = ign_q;
		retry_d = retry_q;
		mant_d = mant_q;
		rdata_d = cmd_rdata;
		ack_d = 1'b0;
		nack_d = 1'b0;
		ivd_d = ivd_q && !fault_clear;
		ivc_d = ivc_q && !fault_clear;
		tmo_d = (tmo_q && !fault_clear) || tmo_event;
		store_d = store_all;
		if (nv_load) begin
			ign_d = nv_ignore_select;
			retry_d = nv_retry_bit;
			mant_d = nv_toff_mant;
		end
		if (req) begin
			if (!hit || loop_slave) begin
				// Loop slaves and unknown codes: refuse, write dropped
				nack_d = 1'b1;
				ivc_d = 1'b1;
			end else if (cmd_code == CMD_STARTUP_ACTION) begin
				if (cmd_wr && bad_retry) begin
					// Whole byte rejected so settings never go half-written
					nack_d = 1'b1;
					ivd_d = 1'b1;
				end else begin
					ack_d = 1'b1;
					rdata_d = {8'h00, action_byte};
					if (cmd_wr) begin
						ign_d = cmd_wdata[IGNORE_SELECT_BIT];
						retry_d = cmd_wdata[RETRY_STORED_BIT];
					end
				end
			end else begin
				ack_d = 1'b1;
				// Exponent and upper mantissa bits are fixed zero
				rdata_d = {TOFF_EXPONENT, 4'h0, mant_q};
				if (cmd_wr) begin
					mant_d = cmd_wdata[MANT_W-1:0];
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ign_q <= IGNORE_SELECT_RST;
			retry_q <= RETRY_RST;
			mant_q <= TOFF_MANT_RST;
			cmd_rdata <= '0;
			cmd_ack <= 1'b0;
			cmd_nack <= 1'b0;
			tmo_q <= 1'b0;
			ivd_q <= 1'b0;
			ivc_q <= 1'b0;
			nv_store <= 1'b0;
			nv_action_byte <= '0;
			nv_toff_data <= '0;
		end else begin
			ign_q <= ign_d;
			retry_q <= retry_d;
			mant_q <= mant_d;
			cmd_rdata <= rdata_d;
			cmd_ack <= ack_d;
			cmd_nack <= nack_d;
			tmo_q <= tmo_d;
			ivd_q <= ivd_d;
			ivc_q <= ivc_d;
			nv_store <= store_d;
			if (store_all) begin
				// Only bit 5 carries the retry choice into storage
				nv_action_byte <= {ign_q, 1'b0, retry_q, 5'h00};
				nv_toff_data <= mant_q;
			end
		end
	end

	// Status outputs from flops; alert from flops and the startup_timeout_mask input
	assign startup_timeout_flag = tmo_q;
	assign other_fault = tmo_q;
	assign output_fault_word_bit = tmo_q;
	assign invalid_data_flag = ivd_q;
	assign invalid_command_fault = ivc_q;
	assign communication_fault_summary = ivd_q || ivc_q;
	// Masking gates only the alert, never the flag
	assign alert_b = !((tmo_q && !startup_timeout_mask) || ivd_q || ivc_q);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	ms_timer_if tif ();
	seq_state_t st_q, st_d;
	logic fall_q, fall_d, on_q;
	logic [15:0] retry_wait_ms;

	ms_timer #(
		.CYC_PER_MS(CYC_PER_MS)
	) u_timer (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.tif(tif)
	);

	assign retry_wait_ms = 16'(RETRY_RISE_MULT) * {8'h00, soft_start_rise_time};
	// Limit zero disables the timeout check
	assign tmo_event = (st_q == ST_RISE) && tif.done && below_uvf && (startup_timeout_limit != '0);

	always_comb begin
		st_d = st_q;
		fall_d = 1'b0;
		tif.start = 1'b0;
		tif.load_ms = '0;
		case (st_q)
			ST_IDLE: begin
				if (on_cmd) begin
					st_d = ST_RISE;
					tif.start = 1'b1;
					tif.load_ms = {4'h0, startup_timeout_limit};
				end
			end
			ST_RISE: begin
				if (!on_cmd || other_fault_shutdown) begin
					st_d = ST_STOP_WAIT;
					tif.start = 1'b1;
					tif.load_ms = {9'h000, bucket_ms(mant_q)};
				end else if (!below_uvf) begin
					st_d = ST_ON;
				end else if (tmo_event) begin
					if (!ign_q) begin
						st_d = ST_ON;
					end else if (retry_q) begin
						st_d = ST_RETRY_WAIT;
						tif.start = 1'b1;
						tif.load_ms = retry_wait_ms;
					end else begin
						st_d = ST_FAULT_OFF;
					end
				end
			end
			ST_ON: begin
				if (!on_cmd || other_fault_shutdown) begin
					st_d = ST_STOP_WAIT;
					tif.start = 1'b1;
					tif.load_ms = {9'h000, bucket_ms(mant_q)};
				end
			end
			ST_STOP_WAIT: begin
				if (tif.done) begin
					st_d = ST_IDLE;
					fall_d = 1'b1;
				end
			end
			ST_RETRY_WAIT: begin
				if (!on_cmd || other_fault_shutdown) begin
					st_d = ST_IDLE;
				end else if (tif.done) begin
					st_d = ST_RISE;
					tif.start = 1'b1;
					tif.load_ms = {4'h0, startup_timeout_limit};
				end
			end
			ST_FAULT_OFF: begin
				// No restart and no delay: wait for the fault clear or on_cmd low
				if (fault_clear || !on_cmd) begin
					st_d = ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			st_q <= ST_IDLE;
			fall_q <= 1'b0;
			on_q <= 1'b0;
		end else begin
			st_q <= st_d;
			fall_q <= fall_d;
			on_q <= (st_d == ST_RISE) || (st_d == ST_ON);
		end
	end

	assign ramp_up = (st_q == ST_RISE);
	assign regulating = on_q;
	assign ramp_down = fall_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence s_timeout;
		tmo_event;
	endsequence
	sequence s_flags_up;
		tmo_q && other_fault && output_fault_word_bit;
	endsequence

	a_timeout_needs_low: assert property (tmo_event |-> below_uvf && st_q == ST_RISE)
		else $error("timeout without low output");
	a_timeout_flags_set: assert property (s_timeout |=> s_flags_up)
		else $error("timeout flags not set");
	a_ignore_keeps_on: assert property (s_timeout and !ign_q && on_cmd && !other_fault_shutdown |=> st_q == ST_ON)
		else $error("ignore mode left regulation");
	a_shutdown_on_fault: assert property (s_timeout and ign_q && on_cmd && !other_fault_shutdown |=> !regulating)
		else $error("no shutdown on timeout");
	a_no_retry_off: assert property (st_q == ST_FAULT_OFF && !fault_clear && on_cmd |=> st_q == ST_FAULT_OFF)
		else $error("restart while retry disabled");
	a_retry_wait_entry: assert property (s_timeout and ign_q && retry_q && on_cmd && !other_fault_shutdown
		|=> st_q == ST_RETRY_WAIT)
		else $error("endless retry not entered");
	a_bad_retry_nack: assert property (cmd_wr && cmd_code == CMD_STARTUP_ACTION && !loop_slave && bad_retry
		|=> cmd_nack && invalid_data_flag && !alert_b && $stable(retry_q))
		else $error("bad retry write not rejected");
	a_delay_mirror: assert property (action_byte[2:0] == action_byte[5:3] && action_byte[6] == 1'b0)
		else $error("delay bits differ from retry");
	a_loop_slave_nack: assert property (req && loop_slave && hit |=> cmd_nack && !cmd_ack && invalid_command_fault
		&& $stable(mant_q))
		else $error("loop slave access accepted");
	a_toff_fixed_bits: assert property (cmd_ack && $past(cmd_code) == CMD_TURN_OFF_DELAY |-> cmd_rdata[15:7] == '0)
		else $error("turn-off fixed bits not zero");
	a_zero_delay_fall: assert property (st_q == ST_ON && !on_cmd && mant_q == '0 |=> ##1 ramp_down)
		else $error("zero turn-off delay not immediate");
	a_store_pulse: assert property (store_all |=> nv_store && nv_toff_data == $past(mant_q))
		else $error("store-all did not copy settings");
endmodule

/* fault_delay_pkg.sv */
// Constants for the start-up timeout response and turn-off delay block.
// Assumes a 250 MHz system clock and a byte-wide command code port.
// Summary of operation
// - Flag start-up timeout when output stays below threshold past limit from ramp start.
// - Timeout sets other-fault, output-fault word, timeout flag, and raises alert.
// - Ignore-select 0 keeps regulating, still sets status and alert unless masked.
// - Ignore-select 1 (default) shuts down, then restarts per retry field.
// - Retry field 000 never restarts; output stays off until faults cleared or on_cmd low.
// - Retry field 111 (default) restarts endlessly until off, power loss, other fault.
// - Retry write other than 000/111 rejected; alert, comm summary, invalid data set.
// - Only bits 7 and 5 of the response register go to nonvolatile storage.
// - Delay field 000 means no delay; only with retry disabled, output stays off.
// - Delay field 111 (default) waits seven rise times per restart; retry enabled only.
// - Delay bits are read-only copies of retry bit 5.
// - Wait the turn-off delay between stop request and start of ramp down.
// - Store-all command copies turn-off delay and response settings to nonvolatile memory.
// - Loop-slave units NACK both commands, ignore writes, flag invalid command, alert.
// - Turn-off word: exponent 00000 read-only, upper four mantissa bits zero, low seven writable.
// - Programmed turn-off mantissa maps onto sixteen supported delay values.
// - Buckets 0->0, 1..6 same, 7-9->7, 10-12->10, 13-17->14, 18-22->19 ms.
// - Buckets 23-32->27, 33-44->37, 45-62->52, 63-86->72, above 86->100 ms.
package fault_delay_pkg;
	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_STARTUP_ACTION = 8'h63;
	localparam logic [7:0] CMD_TURN_OFF_DELAY = 8'h64;
	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int IGNORE_SELECT_BIT = 7;
	localparam int RETRY_STORED_BIT = 5;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam logic [2:0] RETRY_OFF = 3'h0;
	localparam logic [2:0] RETRY_ON = 3'h7;
	localparam logic IGNORE_SELECT_RST = 1'b1;
	localparam logic RETRY_RST = 1'b1;
	localparam int MANT_W = 7;
	localparam logic [MANT_W-1:0] TOFF_MANT_RST = 7'h00;
	localparam logic [4:0] TOFF_EXPONENT = 5'h00;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int MS_IN_NS = 1000000;
	localparam int CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
	localparam int RETRY_RISE_MULT = 7;
	localparam int MS_W = 16;
	// Turn-off delay buckets: upper edge of mantissa range and delay in ms
	localparam logic [MANT_W-1:0] EDGE_7 = 7'h09;
	localparam logic [MANT_W-1:0] EDGE_10 = 7'h0C;
	localparam logic [MANT_W-1:0] EDGE_14 = 7'h11;
	localparam logic [MANT_W-1:0] EDGE_19 = 7'h16;
	localparam logic [MANT_W-1:0] EDGE_27 = 7'h20;
	localparam logic [MANT_W-1:0] EDGE_37 = 7'h2C;
	localparam logic [MANT_W-1:0] EDGE_52 = 7'h3E;
	localparam logic [MANT_W-1:0] EDGE_72 = 7'h56;
	localparam logic [MANT_W-1:0] EDGE_DIRECT = 7'h06;
	localparam logic [MANT_W-1:0] MS_100 = 7'h64;
	localparam logic [MANT_W-1:0] MS_72 = 7'h48;
	localparam logic [MANT_W-1:0] MS_52 = 7'h34;
	localparam logic [MANT_W-1:0] MS_37 = 7'h25;
	localparam logic [MANT_W-1:0] MS_27 = 7'h1B;
	localparam logic [MANT_W-1:0] MS_19 = 7'h13;
	localparam logic [MANT_W-1:0] MS_14 = 7'h0E;
	localparam logic [MANT_W-1:0] MS_10 = 7'h0A;
	localparam logic [MANT_W-1:0] MS_7 = 7'h07;
	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RISE = 3'b001,
		ST_ON = 3'b010,
		ST_STOP_WAIT = 3'b011,
		ST_RETRY_WAIT = 3'b100,
		ST_FAULT_OFF = 3'b101
	} seq_state_t;
endpackage

/* ms_timer_if.sv */
// Handshake between the sequencer and its millisecond interval timer.
// Assumes both ends share clk_sys.
`timescale 1ns/1ps
interface ms_timer_if;
	logic start;
	logic [15:0] load_ms;
	logic done;
	modport ctl (output start, output load_ms, input done);
	modport tmr (input start, input load_ms, output done);
endinterface

/* ms_timer.sv */
// Millisecond interval timer with its own tick prescaler.
// Assumes start is a one-cycle pulse from logic on clk_sys.
`timescale 1ns/1ps
module ms_timer #(
	parameter int CYC_PER_MS = fault_delay_pkg::CYCLES_PER_MS
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Sequencer side
	ms_timer_if.tmr tif
);
	import fault_delay_pkg::*;

	logic [17:0] pre_q, pre_d;
	logic [MS_W-1:0] cnt_q, cnt_d;
	logic busy_q, busy_d;
	logic tick;

	// ----------------------------------------------------------------
	// Tick and countdown
	// ----------------------------------------------------------------
	// Prescaler restarts on start, so N ms is exactly N*CYC_PER_MS cycles
	assign tick = (pre_q == 18'(CYC_PER_MS - 1));
	assign tif.done = busy_q && (cnt_q == '0);

	always_comb begin
		pre_d = tick ? '0 : pre_q + 18'h00001;
		cnt_d = cnt_q;
		busy_d = busy_q;
		if (tif.start) begin
			pre_d = '0;
			cnt_d = tif.load_ms;
			busy_d = 1'b1;
		end else if (tif.done) begin
			busy_d = 1'b0;
		end else if (busy_q && tick) begin
			cnt_d = cnt_q - 16'h0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			pre_q <= '0;
			cnt_q <= '0;
			busy_q <= 1'b0;
		end else begin
			pre_q <= pre_d;
			cnt_q <= cnt_d;
			busy_q <= busy_d;
		end
	end
endmodule

/* bus_host.sv */
// ----------------------------------------------------------------
// Behavioural management bus host driving the decoded command port.
// ----------------------------------------------------------------
// Assumes the device answers a taken request within a few cycles.
`timescale 1ns/1ps
module bus_host (
	// Clock
	input wire logic clk_sys,
	// Command port
	output logic [7:0] cmd_code,
	output logic cmd_wr,
	output logic cmd_rd,
	output logic [15:0] cmd_wdata,
	input wire logic [15:0] cmd_rdata,
	input wire logic cmd_ack,
	input wire logic cmd_nack
);
	// Idle port at time zero
	initial begin
		cmd_code = 8'h00;
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		cmd_wdata = 16'h0000;
	end

	// One request pulsed for a single cycle, then the answer is awaited
	task automatic access(input logic rd, input logic [7:0] code, input logic [15:0] wdata,
			output logic [15:0] rdata, output logic refused, output logic answered);
		int n;
		n = 0;
		answered = 1'b0;
		refused = 1'b0;
		rdata = 16'h0000;
		@(negedge clk_sys);
		cmd_code = code;
		cmd_wdata = wdata;
		cmd_rd = rd;
		cmd_wr = !rd;
		@(negedge clk_sys);
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		// Released lines flip so a stale value can never look valid
		cmd_code = ~code;
		cmd_wdata = ~wdata;
		while (answered == 1'b0 && n < 4) begin
			if (cmd_ack === 1'b1 || cmd_nack === 1'b1) begin
				answered = 1'b1;
				refused = cmd_nack;
				rdata = cmd_rdata;
			end else begin
				n++;
				@(negedge clk_sys);
			end
		end
	endtask
endmodule

/* testbench.sv */
// ----------------------------------------------------------------
// Self-checking bench for the start-up fault response block.
// ----------------------------------------------------------------
// Assumes a 10-cycle millisecond so every delay stays short.
`timescale 1ns/1ps
module testbench;
	import fault_delay_pkg::*;
	localparam int CYC = 10;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] cmd_code;
	logic cmd_wr, cmd_rd, cmd_ack, cmd_nack, nv_store;
	logic [15:0] cmd_wdata, cmd_rdata;
	logic store_all = 1'b0, nv_load = 1'b0, nv_ignore_select = 1'b0, nv_retry_bit = 1'b0;
	logic [6:0] nv_toff_mant = 7'h00, nv_toff_data;
	logic [7:0] nv_action_byte;
	logic loop_slave_pin = 1'b0, out_below_uvf_pin = 1'b0, on_cmd = 1'b0, other_fault_shutdown = 1'b0;
	logic [11:0] startup_timeout_limit = 12'h000;
	logic [7:0] soft_start_rise_time = 8'h01;
	logic fault_clear = 1'b0, startup_timeout_mask = 1'b0;
	logic ramp_up, regulating, ramp_down, startup_timeout_flag, other_fault, output_fault_word_bit;
	logic communication_fault_summary, invalid_data_flag, invalid_command_fault, alert_b;
	int fails = 0;
	int check_count = 0;
	int n;
	int mant [17] = '{0, 6, 7, 9, 10, 13, 17, 18, 23, 32, 33, 45, 62, 63, 86, 87, 127};
	int msv [17] = '{0, 6, 7, 7, 10, 14, 14, 19, 27, 27, 37, 52, 52, 72, 72, 100, 100};

	always #2 clk_sys = ~clk_sys;

	startup_fault_response_and_turnoff_delay #(.CYC_PER_MS(CYC)) startup_fault_response_and_turnoff_delay_i (
		.clk_sys(clk_sys), .rst_b(rst_b), .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack),
		.store_all(store_all), .nv_load(nv_load), .nv_ignore_select(nv_ignore_select),
		.nv_retry_bit(nv_retry_bit), .nv_toff_mant(nv_toff_mant), .nv_store(nv_store),
		.nv_action_byte(nv_action_byte), .nv_toff_data(nv_toff_data), .loop_slave_pin(loop_slave_pin),
		.out_below_uvf_pin(out_below_uvf_pin), .on_cmd(on_cmd), .other_fault_shutdown(other_fault_shutdown),
		.startup_timeout_limit(startup_timeout_limit), .soft_start_rise_time(soft_start_rise_time),
		.ramp_up(ramp_up), .regulating(regulating), .ramp_down(ramp_down), .fault_clear(fault_clear),
		.startup_timeout_mask(startup_timeout_mask), .startup_timeout_flag(startup_timeout_flag),
		.other_fault(other_fault), .output_fault_word_bit(output_fault_word_bit),
		.communication_fault_summary(communication_fault_summary), .invalid_data_flag(invalid_data_flag),
		.invalid_command_fault(invalid_command_fault), .alert_b(alert_b));

	bus_host bus_host_i (.clk_sys(clk_sys), .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic test_done();
		if (fails == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Read or write, checking refusal and, when accepted on a read, the data
	task automatic req(input logic rd, input logic [7:0] code, input logic [15:0] wd,
			input logic exp_nack, input logic [15:0] exp_data);
		logic [15:0] d;
		logic nk, ok;
		bus_host_i.access(rd, code, wd, d, nk, ok);
		check({15'h0000, ok}, 16'h0001);
		check({15'h0000, nk}, {15'h0000, exp_nack});
		if (rd && !exp_nack) begin
			check(d, exp_data);
		end
	endtask

	// Reset held six cycles; leaves the sequencer inputs quiet
	task automatic do_reset();
		@(negedge clk_sys);
		rst_b = 1'b0;
		on_cmd = 1'b0;
		out_below_uvf_pin = 1'b0;
		startup_timeout_limit = 12'h000;
		repeat (6) @(negedge clk_sys);
		rst_b = 1'b1;
	endtask

	// Bounded wait on a settled signal level, counting cycles
	task automatic wait_for(ref logic sig, input logic lvl, input int lim);
		n = 0;
		while (sig !== lvl && n < lim) begin
			n++;
			@(negedge clk_sys);
		end
		if (sig !== lvl) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, sig, lvl);
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		do_reset();
		req(1'b1, CMD_STARTUP_ACTION, 16'h0000, 1'b0, 16'h00BF);
		req(1'b1, CMD_TURN_OFF_DELAY, 16'h0000, 1'b0, 16'h0000);
		req(1'b0, CMD_TURN_OFF_DELAY, 16'hFFFF, 1'b0, 16'h0000);
		req(1'b1, CMD_TURN_OFF_DELAY, 16'h0000, 1'b0, 16'h007F);
		req(1'b0, CMD_STARTUP_ACTION, 16'h0078, 1'b0, 16'h0000);
		req(1'b1, CMD_STARTUP_ACTION, 16'h0000, 1'b0, 16'h003F);
		req(1'b0, CMD_STARTUP_ACTION, 16'h0080, 1'b0, 16'h0000);
		req(1'b1, CMD_STARTUP_ACTION, 16'h0000, 1'b0, 16'h0080);
		// Every mixed retry pattern is refused and leaves the byte alone
		for (int v = 1; v < 7; v++) begin
			req(1'b0, CMD_STARTUP_ACTION, 16'(v << 3), 1'b1, 16'h0000);
		end
		req(1'b1, CMD_STARTUP_ACTION, 16'h0000, 1'b0, 16'h0080);
		check(invalid_data_flag, 1'b1);
		check(communication_fault_summary, 1'b1);
		check(alert_b, 1'b0);
		// Store and restore of the nonvolatile copies
		req(1'b0, CMD_TURN_OFF_DELAY, 16'h002A, 1'b0, 16'h0000);
		store_all = 1'b1;
		@(negedge clk_sys);
		store_all = 1'b0;
		check(nv_store, 1'b1);
		check(nv_action_byte, 8'h80);
		check(nv_toff_data, 7'h2A);
		nv_retry_bit = 1'b1;
		nv_toff_mant = 7'h11;
		nv_load = 1'b1;
		@(negedge clk_sys);
		nv_load = 1'b0;
		req(1'b1, CMD_STARTUP_ACTION, 16'h0000, 1'b0, 16'h003F);
		req(1'b1, CMD_TURN_OFF_DELAY, 16'h0000, 1'b0, 16'h0011);
		// Loop slave: both commands refused, writes dropped
		do_reset();
		loop_slave_pin = 1'b1;
		repeat (8) @(negedge clk_sys);
		req(1'b0, CMD_TURN_OFF_DELAY, 16'h0005, 1'b1, 16'h0000);
		req(1'b1, CMD_STARTUP_ACTION, 16'h0000, 1'b1, 16'h0000);
		check(invalid_command_fault, 1'b1);
		check(alert_b, 1'b0);
		loop_slave_pin = 1'b0;
		repeat (8) @(negedge clk_sys);
		req(1'b1, CMD_TURN_OFF_DELAY, 16'h0000, 1'b0, 16'h0000);
		// Turn-off delay at the bucket edges, measured stop to ramp-down
		do_reset();
		for (int i = 0; i < 17; i++) begin
			req(1'b0, CMD_TURN_OFF_DELAY, 16'(mant[i]), 1'b0, 16'h0000);
			on_cmd = 1'b1;
			repeat (12) @(negedge clk_sys);
			on_cmd = 1'b0;
			@(negedge clk_sys);
			wait_for(ramp_down, 1'b1, 1200);
			check(16'((n + 1) / CYC), 16'(msv[i]));
		end
		// Ignored timeout: status set, output keeps running, alert maskable
		do_reset();
		req(1'b0, CMD_STARTUP_ACTION, 16'h0038, 1'b0, 16'h0000);
		startup_timeout_limit = 12'h002;
		out_below_uvf_pin = 1'b1;
		// Let the pin synchroniser settle, or the ramp sees a good output at once
		repeat (5) @(negedge clk_sys);
		on_cmd = 1'b1;
		wait_for(startup_timeout_flag, 1'b1, 60);
		check(16'(n / CYC), 16'h0002);
		check({other_fault, output_fault_word_bit, alert_b}, 3'b110);
		repeat (30) @(negedge clk_sys);
		check(regulating, 1'b1);
		startup_timeout_mask = 1'b1;
		@(negedge clk_sys);
		check(alert_b, 1'b1);
		startup_timeout_mask = 1'b0;
		// Shutdown without retry stays off
		do_reset();
		req(1'b0, CMD_STARTUP_ACTION, 16'h0080, 1'b0, 16'h0000);
		startup_timeout_limit = 12'h001;
		out_below_uvf_pin = 1'b1;
		repeat (5) @(negedge clk_sys);
		on_cmd = 1'b1;
		wait_for(startup_timeout_flag, 1'b1, 40);
		repeat (100) @(negedge clk_sys);
		check({regulating, ramp_up}, 2'b00);
		// Fault clear drops the flag and lets a new soft start begin
		fault_clear = 1'b1;
		@(negedge clk_sys);
		fault_clear = 1'b0;
		check(startup_timeout_flag, 1'b0);
		@(negedge clk_sys);
		check(ramp_up, 1'b1);
		// Default retry: seven rise times off, then a fresh soft start, repeated
		do_reset();
		startup_timeout_limit = 12'h001;
		out_below_uvf_pin = 1'b1;
		repeat (5) @(negedge clk_sys);
		on_cmd = 1'b1;
		wait_for(startup_timeout_flag, 1'b1, 40);
		wait_for(regulating, 1'b0, 10);
		wait_for(regulating, 1'b1, 200);
		check(16'(n / CYC), 16'h0007);
		wait_for(regulating, 1'b0, 40);
		check(ramp_up, 1'b0);
		wait_for(ramp_up, 1'b1, 200);
		check(ramp_up, 1'b1);
		on_cmd = 1'b0;
		test_done();
	end

	// Watchdog well beyond the expected run length of under ten thousand cycles
	initial begin
		#100000;
		fails++;
		test_done();
	end
endmodule
